// ### hdl/reru_top.sv
// Radio error reporting unit: latches the newest error code into a
// clear-on-read register and raises an alert line through a mask.
// Assumes error inputs are one-cycle pulses from logic on ref_clk and
// software reaches the registers over a plain strobe port.
`timescale 1ns/1ns
// Contract
// - Detected error places its code in register.
// - Reading code register returns it, then clears.
// - New error overwrites held code, no queue.
// - Alert asserted when code AND mask nonzero.
// - Alert holds until host reads code register; also drops when mask write or new code leaves code AND mask zero.
// - Mask gates alert only; all errors recorded.
// - Mask 0x08 passes only buffer overruns.
// - Mask 0x10 passes only register write failure.
// - Mask 0x20 passes only missing acknowledgement.
// - Mask 0x40 passes only packet integrity errors.
// - Mask 0xFF passes every error code.
// - Record radio and UART buffer overruns separately.
// - Record failed register write.
// - Record missing acknowledgement after retries exhausted.
// - Record payload and header check failures distinctly.
// - Record acknowledgement sequence number mismatch.
// - Record unsupported frame kind; other codes reserved.
// - Retry limit comes from retry limit register.
module reru_top #(
	parameter int RETRY_W = 8
) (
	// Clock and reset.
	input  wire logic                 ref_clk,
	input  wire logic                 resetn,
	// Register port.
	input  wire logic [3:0]           reg_addr,
	input  wire logic [7:0]           reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic      [7:0]           reg_rdata,
	// Error events from the controller.
	input  wire logic                 uart_buffer_overrun,
	input  wire logic                 radio_buffer_overrun,
	input  wire logic                 reg_write_fail,
	input  wire logic                 payload_check_fail,
	input  wire logic                 header_check_fail,
	input  wire logic                 ack_sequence_mismatch,
	input  wire logic                 unsupported_frame_kind,
	// Transmit progress for the retry monitor.
	input  wire logic                 tx_start,
	input  wire logic                 tx_retry,
	input  wire logic                 ack_ok,
	// Host alert line, active high.
	output logic                      error_alert_line,
	// Retry limit for the transmitter.
	output logic      [RETRY_W-1:0]   retry_limit
);

	initial begin
		if (RETRY_W < 1 || RETRY_W > 8) begin
			$error("reru_top: RETRY_W must be 1 to 8");
		end
	end

	// State of the block, apart from the retry monitor's own registers, in one struct.
	typedef struct packed {
		logic [7:0]         code;
		logic [7:0]         mask;
		logic [RETRY_W-1:0] retry;
		logic [7:0]         rdata;
		logic               alert;
		logic [7:0]         err_count;
	} reru_state_s;

	reru_state_s             st_r;
	reru_state_s             st_nxt;
	reru_pkg::reru_err_s     err;
	reru_pkg::reru_bus_s     bus;
	logic                    ack_missing;
	logic                    any_err;
	logic [7:0]              new_code;
	logic [7:0]              held_after;

	// Retransmission watcher driven by the stored retry limit.
	reru_retry_mon #(
		.CNT_W               (RETRY_W)
	) u_retry_mon (
		.ref_clk             (ref_clk),
		.resetn              (resetn),
		.tx_start            (tx_start),
		.tx_retry            (tx_retry),
		.ack_ok              (ack_ok),
		.retry_limit         (st_r.retry),
		.ack_retries_used_up (ack_missing)
	);

	// Gather events and the register request into their carriers.
	always_comb begin
		err.uart_buffer_overrun    = uart_buffer_overrun;
		err.radio_buffer_overrun   = radio_buffer_overrun;
		err.reg_write_fail         = reg_write_fail;
		err.ack_retries_used_up    = ack_missing;
		err.payload_check_fail     = payload_check_fail;
		err.header_check_fail      = header_check_fail;
		err.ack_sequence_mismatch  = ack_sequence_mismatch;
		err.unsupported_frame_kind = unsupported_frame_kind;
		bus.addr                   = reg_addr;
		bus.wdata                  = reg_wdata;
		bus.wr                     = reg_wr;
		bus.rd                     = reg_rd;
	end

	// Map the event set to one code. Should two events coincide, the
	// later-listed source is taken; only one code can be held anyway.
	function automatic logic [7:0] err_to_code(reru_pkg::reru_err_s e);
		logic [7:0] c;
		c = reru_pkg::CODE_EMPTY;
		if (e.uart_buffer_overrun) begin
			c = reru_pkg::CODE_UART_OVR;
		end
		if (e.radio_buffer_overrun) begin
			c = reru_pkg::CODE_RADIO_OVR;
		end
		if (e.reg_write_fail) begin
			c = reru_pkg::CODE_REG_WRITE;
		end
		if (e.ack_retries_used_up) begin
			c = reru_pkg::CODE_ACK_RETRY;
		end
		if (e.payload_check_fail) begin
			c = reru_pkg::CODE_PAYLOAD;
		end
		if (e.header_check_fail) begin
			c = reru_pkg::CODE_HEADER;
		end
		if (e.ack_sequence_mismatch) begin
			c = reru_pkg::CODE_SEQUENCE;
		end
		if (e.unsupported_frame_kind) begin
			c = reru_pkg::CODE_FRAME_KIND;
		end
		return c;
	endfunction

	// Masking test; used for the alert only, the status view returns the error count.
	function automatic logic masked_hit(logic [7:0] c, logic [7:0] m);
		return (c & m) != 8'h00;
	endfunction

	// Error detection and the code the register will hold afterwards.
	always_comb begin
		new_code = err_to_code(err);
		any_err  = (err != '0);
		if (any_err) begin
			held_after = new_code;
		end else if (bus.rd && bus.addr == reru_pkg::ADDR_CODE) begin
			held_after = reru_pkg::CODE_EMPTY;
		end else begin
			held_after = st_r.code;
		end
	end

	// Next state. An error in the same cycle as the clearing read wins,
	// so no event is lost; the read still returns the old code.
	always_comb begin
		st_nxt       = st_r;
		st_nxt.rdata = reru_pkg::RD_IDLE;
		st_nxt.code  = held_after;

		// Register writes. The code register is read only.
		if (bus.wr) begin
			unique case (bus.addr)
				reru_pkg::ADDR_MASK: begin
					st_nxt.mask = bus.wdata;
				end
				reru_pkg::ADDR_RETRY: begin
					st_nxt.retry = bus.wdata[RETRY_W-1:0];
				end
				default: begin
					st_nxt.mask = st_r.mask;
				end
			endcase
		end

		// Register reads; data stands in the next cycle only.
		if (bus.rd) begin
			unique case (bus.addr)
				reru_pkg::ADDR_CODE: begin
					st_nxt.rdata = st_r.code;
				end
				reru_pkg::ADDR_MASK: begin
					st_nxt.rdata = st_r.mask;
				end
				reru_pkg::ADDR_RETRY: begin
					st_nxt.rdata = 8'(st_r.retry);
				end
				reru_pkg::ADDR_STATUS: begin
					st_nxt.rdata = st_r.err_count;
				end
				default: begin
					st_nxt.rdata = reru_pkg::RD_IDLE;
				end
			endcase
		end

		// Count of recorded errors, saturating, for diagnostics.
		if (any_err && st_r.err_count != 8'hFF) begin
			st_nxt.err_count = st_r.err_count + 8'h01;
		end

		// Alert follows the held code through the mask. Since only a code
		// read empties the register, the line stays up until that read or a new code outside the mask.
		// A mask change re-evaluates at once; follow.
		st_nxt.alert = masked_hit(held_after, st_nxt.mask);
	end

	// State register: resets to empty code and a quiet alert line.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			st_r.code      <= reru_pkg::CODE_EMPTY;
			st_r.mask      <= reru_pkg::MASK_RESET;
			st_r.retry     <= RETRY_W'(reru_pkg::RETRY_RESET);
			st_r.rdata     <= reru_pkg::RD_IDLE;
			st_r.alert     <= 1'b0;
			st_r.err_count <= 8'h00;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from flip-flops.
	assign reg_rdata        = st_r.rdata;
	assign error_alert_line = st_r.alert;
	assign retry_limit      = st_r.retry;

endmodule // reru_top

// ### hdl/reru_pkg.sv
// Package for the radio error reporting unit: register map, error codes,
// reset values and the carrier structs shared by the block's files.
// Assumes a single controller clock and a plain strobe register port.
package reru_pkg;

	// Register offsets on the plain register port.
	localparam logic [3:0] ADDR_CODE   = 4'h0;
	localparam logic [3:0] ADDR_MASK   = 4'h1;
	localparam logic [3:0] ADDR_RETRY  = 4'h2;
	localparam logic [3:0] ADDR_STATUS = 4'h3;

	// Group mask bits; every code of a group lies inside its group bit.
	localparam logic [7:0] GRP_OVERFLOW = 8'h08;
	localparam logic [7:0] GRP_REGWRITE = 8'h10;
	localparam logic [7:0] GRP_ACK      = 8'h20;
	localparam logic [7:0] GRP_PACKET   = 8'h40;

	// Error codes: distinct, and each carries its own group bit and no other group's bit.
	localparam logic [7:0] CODE_UART_OVR   = 8'h08;
	localparam logic [7:0] CODE_RADIO_OVR  = 8'h09;
	localparam logic [7:0] CODE_REG_WRITE  = 8'h10;
	localparam logic [7:0] CODE_ACK_RETRY  = 8'h20;
	localparam logic [7:0] CODE_PAYLOAD    = 8'h40;
	localparam logic [7:0] CODE_HEADER     = 8'h41;
	localparam logic [7:0] CODE_SEQUENCE   = 8'h42;
	localparam logic [7:0] CODE_FRAME_KIND = 8'h43;

	// Values after reset.
	localparam logic [7:0] CODE_EMPTY  = 8'h00;
	localparam logic [7:0] MASK_RESET  = 8'hFF;
	localparam logic [7:0] RETRY_RESET = 8'h03;
	localparam logic [7:0] RD_IDLE     = 8'h00;

	// Number of error sources.
	localparam int NUM_SRC = 8;

	// Raw error events from the rest of the controller.
	typedef struct packed {
		logic uart_buffer_overrun;
		logic radio_buffer_overrun;
		logic reg_write_fail;
		logic ack_retries_used_up;
		logic payload_check_fail;
		logic header_check_fail;
		logic ack_sequence_mismatch;
		logic unsupported_frame_kind;
	} reru_err_s;

	// Register port request.
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reru_bus_s;

endpackage : reru_pkg

// ### hdl/reru_retry_mon.sv
// Retry monitor: counts retransmissions of the current packet and raises
// the missing-acknowledgement event once they exceed the stored limit.
// Assumes tx_retry and ack_ok are one-cycle pulses on ref_clk.
`timescale 1ns/1ns
module reru_retry_mon #(
	parameter int CNT_W = 8
) (
	// Clock and reset.
	input  wire logic             ref_clk,
	input  wire logic             resetn,
	// Transmit progress.
	input  wire logic             tx_start,
	input  wire logic             tx_retry,
	input  wire logic             ack_ok,
	input  wire logic [CNT_W-1:0] retry_limit,
	// Event out.
	output logic                  ack_retries_used_up
);

	initial begin
		if (CNT_W < 1 || CNT_W > 16) begin
			$error("reru_retry_mon: CNT_W out of range");
		end
	end

	typedef struct packed {
		logic [CNT_W:0] cnt;
		logic           busy;
		logic           ev;
	} reru_mon_s;

	reru_mon_s st_r;
	reru_mon_s st_nxt;

	// The count is one bit wider than the limit so it can pass it.
	always_comb begin
		st_nxt    = st_r;
		st_nxt.ev = 1'b0;
		if (tx_start) begin
			st_nxt.cnt  = '0;
			st_nxt.busy = 1'b1;
		end else if (ack_ok) begin
			st_nxt.busy = 1'b0;
		end else if (st_r.busy && tx_retry) begin
			st_nxt.cnt = st_r.cnt + 1'b1;
			if ((st_r.cnt + 1'b1) > {1'b0, retry_limit}) begin
				st_nxt.ev   = 1'b1;
				st_nxt.busy = 1'b0;
			end
		end
	end

	// State register; only constants under reset.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign ack_retries_used_up = st_r.ev;

endmodule // reru_retry_mon

// ### sim/reru_top_props.sv
// Checker for the error reporting unit, bound to every reru_top.
// Assumes one clock domain and one-cycle error pulses at the inputs.
`timescale 1ns/1ns
module reru_top_props #(
	parameter int RETRY_W = 8
) (
	// Clock and reset.
	input wire logic		ref_clk,
	input wire logic		resetn,
	// Register port.
	input wire logic [3:0]		reg_addr,
	input wire logic [7:0]		reg_wdata,
	input wire logic		reg_wr,
	input wire logic		reg_rd,
	input wire logic [7:0]		reg_rdata,
	// Error events.
	input wire logic		uart_buffer_overrun,
	input wire logic		radio_buffer_overrun,
	input wire logic		reg_write_fail,
	input wire logic		payload_check_fail,
	input wire logic		header_check_fail,
	input wire logic		ack_sequence_mismatch,
	input wire logic		unsupported_frame_kind,
	input wire logic		tx_retry,
	// Outputs of the unit.
	input wire logic		error_alert_line,
	input wire logic [RETRY_W-1:0]	retry_limit
);
	logic [7:0]	mask_r;
	logic		ev_hi;
	logic		ev_any;
	logic		mw;
	logic		busy;
	// Sources that outrank the UART overrun, and anything moving the code.
	assign ev_hi = radio_buffer_overrun | reg_write_fail | payload_check_fail
		| header_check_fail | ack_sequence_mismatch | unsupported_frame_kind;
	assign ev_any = ev_hi | uart_buffer_overrun;
	assign mw = reg_wr && reg_addr == reru_pkg::ADDR_MASK;
	assign busy = ev_any | mw | (reg_rd && reg_addr == reru_pkg::ADDR_CODE);
	// Shadow mask, so alert checks never peek inside the design.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			mask_r <= reru_pkg::MASK_RESET;
		end else if (mw) begin
			mask_r <= reg_wdata;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	// A code read with no event in flight, the retry event included.
	sequence clr_rd;
		reg_rd && reg_addr == reru_pkg::ADDR_CODE && !ev_any && !tx_retry
			&& !$past(tx_retry);
	endsequence
	reset_state_a: assert property ($rose(resetn) |->
		!error_alert_line && retry_limit == RETRY_W'(reru_pkg::RETRY_RESET))
		else $error("wrong state after reset");
	alert_drop_a: assert property (clr_rd |=> !error_alert_line)
		else $error("alert stayed after code read");
	read_empty_a: assert property (clr_rd ##1 !ev_any && !tx_retry
		##1 clr_rd |=> reg_rdata == reru_pkg::CODE_EMPTY)
		else $error("code not cleared by read");
	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside read cycle");
	alert_hold_a: assert property (error_alert_line && !busy
		&& !$past(busy) && !$past(tx_retry) |=> error_alert_line)
		else $error("alert dropped without read");
	rise_cause_a: assert property ($rose(error_alert_line) |->
		$past(ev_any) || $past(tx_retry, 2) || $past(mw) || $past(mw, 2))
		else $error("alert rose without cause");
	uart_alert_a: assert property (uart_buffer_overrun && !ev_hi
		&& !$past(tx_retry)
		|=> error_alert_line == |(reru_pkg::CODE_UART_OVR & mask_r))
		else $error("uart overrun alert wrong");
	frame_alert_a: assert property (unsupported_frame_kind |=>
		error_alert_line == |(reru_pkg::CODE_FRAME_KIND & mask_r))
		else $error("frame kind alert wrong");
	retry_write_a: assert property (reg_wr
		&& reg_addr == reru_pkg::ADDR_RETRY
		|=> retry_limit == RETRY_W'($past(reg_wdata)))
		else $error("retry limit not written");
endmodule // reru_top_props

bind reru_top reru_top_props #(.RETRY_W(RETRY_W)) i_reru_top_props (
	.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .uart_buffer_overrun(uart_buffer_overrun),
	.radio_buffer_overrun(radio_buffer_overrun),
	.reg_write_fail(reg_write_fail), .payload_check_fail(payload_check_fail),
	.header_check_fail(header_check_fail), .tx_retry(tx_retry),
	.ack_sequence_mismatch(ack_sequence_mismatch),
	.unsupported_frame_kind(unsupported_frame_kind),
	.error_alert_line(error_alert_line), .retry_limit(retry_limit));

// ### sim/reru_host.sv
// Host model: masters the plain register port of the unit.
// Assumes the caller runs one bus task at a time.
`timescale 1ns/1ns
module reru_host (
	// Clock.
	input wire logic	ref_clk,
	// Register port.
	output logic [3:0]	reg_addr = 4'h0,
	output logic [7:0]	reg_wdata = 8'h00,
	output logic		reg_wr = 1'b0,
	output logic		reg_rd = 1'b0,
	input wire logic [7:0]	reg_rdata
);
	// One-cycle write strobe; the unit never stalls the host.
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	// Reading the code releases the alert; so does writing a mask that no longer shares a bit with the held code.
	task automatic rd(input logic [3:0] a, output logic [7:0] q);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		q = reg_rdata;
	endtask
endmodule // reru_host

// ### sim/tb_reru_top.sv
// Testbench for the error reporting unit: masks, every source, overwrite,
// clear on read and the retry monitor. Assumes reru_host and the checker.
`timescale 1ns/1ns
module tb_reru_top;
	logic		ref_clk = 1'b0;
	logic		resetn = 1'b0;
	logic [9:0]	sig = 10'h000;
	logic [3:0]	reg_addr;
	logic [7:0]	reg_wdata;
	logic		reg_wr;
	logic		reg_rd;
	logic [7:0]	reg_rdata;
	logic		alert;
	logic [7:0]	retry_limit;
	logic [7:0]	q;
	logic [7:0]	m;
	int		fails = 0;
	int		n_checks = 0;
	int		seed = 90406;
	// Expected codes by bit of sig, and the example masks.
	logic [7:0] codes [7] = '{reru_pkg::CODE_UART_OVR, reru_pkg::CODE_RADIO_OVR,
		reru_pkg::CODE_REG_WRITE, reru_pkg::CODE_PAYLOAD, reru_pkg::CODE_HEADER,
		reru_pkg::CODE_SEQUENCE, reru_pkg::CODE_FRAME_KIND};
	logic [7:0] masks [5] = '{8'h08, 8'h10, 8'h20, 8'h40, 8'hFF};

	// Clock of 20 ns period.
	always #10 ref_clk = ~ref_clk;

	reru_top i_reru_top (.ref_clk(ref_clk), .resetn(resetn),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.uart_buffer_overrun(sig[0]), .radio_buffer_overrun(sig[1]),
		.reg_write_fail(sig[2]), .payload_check_fail(sig[3]),
		.header_check_fail(sig[4]), .ack_sequence_mismatch(sig[5]),
		.unsupported_frame_kind(sig[6]), .tx_start(sig[7]),
		.tx_retry(sig[8]), .ack_ok(sig[9]),
		.error_alert_line(alert), .retry_limit(retry_limit));
	reru_host i_reru_host (.ref_clk(ref_clk), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata));

	// The alert is high exactly when code and mask share a bit.
	function automatic logic [7:0] exp_alert(logic [7:0] c, logic [7:0] k);
		return {7'h00, |(c & k)};
	endfunction
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		n_checks++;
		if (s !== e) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	// One-cycle pulse on the event and transmit inputs.
	task automatic pulse(input logic [9:0] v);
		@(posedge ref_clk);
		sig <= v;
		@(posedge ref_clk);
		sig <= 10'h000;
		#1;
	endtask
	task automatic rdc(input logic [7:0] e);
		i_reru_host.rd(reru_pkg::ADDR_CODE, q);
		chk(q, e);
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Watchdog, far beyond the few hundred cycles the tests need.
	initial begin
		#200000;
		fails++;
		stop_test();
	end
	// Main sequence.
	initial begin
		repeat (6) @(posedge ref_clk);
		resetn <= 1'b1;
		#1;
		chk({7'h00, alert}, 8'h00);
		rdc(reru_pkg::CODE_EMPTY);
		i_reru_host.rd(reru_pkg::ADDR_MASK, q);
		chk(q, reru_pkg::MASK_RESET);
		chk(retry_limit, reru_pkg::RETRY_RESET);
		i_reru_host.rd(4'hF, q);
		chk(q, reru_pkg::RD_IDLE);
		i_reru_host.rd(reru_pkg::ADDR_STATUS, q);
		chk(q, 8'h00);
		$display("reset test done");
		for (int k = 0; k < 8; k++) begin
			m = (k < 5) ? masks[k] : 8'($random(seed));
			i_reru_host.wr(reru_pkg::ADDR_MASK, m);
			for (int i = 0; i < 7; i++) begin
				pulse(10'h001 << i);
				chk({7'h00, alert}, exp_alert(codes[i], m));
				rdc(codes[i]);
				chk({7'h00, alert}, 8'h00);
			end
		end
		$display("mask test done");
		i_reru_host.wr(reru_pkg::ADDR_MASK, 8'hFF);
		pulse(10'h001);
		repeat (4) @(posedge ref_clk);
		chk({7'h00, alert}, 8'h01);
		pulse(10'h010);
		rdc(reru_pkg::CODE_HEADER);
		rdc(reru_pkg::CODE_EMPTY);
		pulse(10'h041);
		rdc(reru_pkg::CODE_FRAME_KIND);
		i_reru_host.wr(reru_pkg::ADDR_CODE, 8'h55);
		rdc(reru_pkg::CODE_EMPTY);
		$display("overwrite test done");
		i_reru_host.wr(reru_pkg::ADDR_RETRY, 8'h02);
		chk(retry_limit, 8'h02);
		pulse(10'h080);
		pulse(10'h200);
		repeat (3) pulse(10'h100);
		repeat (3) @(posedge ref_clk);
		rdc(reru_pkg::CODE_EMPTY);
		pulse(10'h080);
		repeat (2) pulse(10'h100);
		repeat (3) @(posedge ref_clk);
		rdc(reru_pkg::CODE_EMPTY);
		// Only the acknowledgement group may raise the line from here on.
		i_reru_host.wr(reru_pkg::ADDR_MASK, 8'h20);
		pulse(10'h100);
		repeat (3) @(posedge ref_clk);
		chk({7'h00, alert}, 8'h01);
		rdc(reru_pkg::CODE_ACK_RETRY);
		$display("retry test done");
		stop_test();
	end
endmodule // tb_reru_top
